// ===== verilog/dram_refresh_test_addr_mux.sv
// dynamic ram controller core: address multiplexing, refresh and test cycle
// Summary of operation
// - read, write and chip select together request a test cycle
// - a test cycle clears the refresh row counter then writes
// - an 8-bit selector picks row, column or refresh address
// - the refresh row counter is 8 bits wide
// - all 256 rows are refreshed within every 4 ms
// - refresh drives bit 7 of the row only in large-ram mode; otherwise bit 7 is held low
// - an internal refresh is requested every 15.6 us and starts once the current cycle ends
// - every strobe and address timing is a whole count of clocks
// - density select low gives two-bank large-ram mode
// - when idle the low-half address passes straight out as row
// - bank selects latched while idle pick the row strobe; host holds them until the cycle starts
`timescale 1ns/1ps
module dram_refresh_test_addr_mux
    import dram_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic read_req_n,
    input wire logic write_req_n,
    input wire logic port_chip_select_n,
    input wire logic [6:0] low_half_addr_in,
    input wire logic [6:0] high_half_addr_in,
    input wire logic low_half_addr_bit7_in,
    input wire logic high_half_addr_bit7_in,
    input wire logic [1:0] bank_select_in,
    input wire logic bank_select_bit0,
    input wire logic ram_density_select,
    output logic [6:0] ram_addr_out,
    output logic ram_addr_out_bit7,
    output logic [3:0] row_strobe_n,
    output logic col_strobe_n,
    output logic ram_write_n,
    output logic cycle_ack
);
    typedef enum logic [2:0] {
        IDLE, ACCESS_ROW, ACCESS_COL, REFRESH_SETUP, REFRESH_STROBE, PRECHARGE
    } state_t;

    // synchronisers for the read, write, chip select and density pin inputs
    logic [1:0] rd_sync_q, wr_sync_q, cs_sync_q, dens_sync_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_sync_q <= 2'h3;
            wr_sync_q <= 2'h3;
            cs_sync_q <= 2'h3;
            dens_sync_q <= 2'h3;
        end else begin
            rd_sync_q <= {rd_sync_q[0], read_req_n};
            wr_sync_q <= {wr_sync_q[0], write_req_n};
            cs_sync_q <= {cs_sync_q[0], port_chip_select_n};
            dens_sync_q <= {dens_sync_q[0], ram_density_select};
        end
    end
    wire logic rd_act = !rd_sync_q[1];
    wire logic wr_act = !wr_sync_q[1];
    wire logic cs_act = !cs_sync_q[1];
    wire logic large_mode = !dens_sync_q[1];
    // all three strobes together mean a test cycle, never a plain write
    wire logic test_req = rd_act && wr_act && cs_act;
    wire logic mem_req = cs_act && (rd_act || wr_act);

    // address paths pass straight through; the ram samples them only under strobes
    wire logic [ADDR_WIDTH-1:0] row_addr =
        {large_mode ? low_half_addr_bit7_in : 1'b0, low_half_addr_in};
    wire logic [ADDR_WIDTH-1:0] col_addr =
        {large_mode ? high_half_addr_bit7_in : 1'b0, high_half_addr_in};
    // bank decode is latched into bank_q while idle, so the host need hold it only until the cycle starts
    wire logic [1:0] bank = large_mode ? {1'b0, bank_select_bit0} : bank_select_in;

    state_t state_q, state_d;
    logic [PHASE_COUNT_WIDTH-1:0] phase_q, phase_d;
    logic [ROW_COUNT_WIDTH-1:0] refresh_row_q, refresh_row_d;
    logic [REFRESH_COUNT_WIDTH-1:0] interval_q;
    logic refresh_due_q;
    logic test_q, test_d;
    logic write_q, write_d;
    logic acc_q, acc_d;
    logic [1:0] bank_q, bank_d;

    wire logic interval_done = (interval_q == REFRESH_COUNT_WIDTH'(REFRESH_INTERVAL_CYCLES - 1));
    wire logic refresh_taken = (state_q == REFRESH_SETUP);
    wire logic [PHASE_COUNT_WIDTH-1:0] phase_inc = phase_q + 4'h1;
    wire logic phase_end_row =
        (phase_q == PHASE_COUNT_WIDTH'(ROW_HOLD_CYCLES + ROW_TO_COL_CYCLES - 1));
    wire logic phase_end_col = (phase_q == PHASE_COUNT_WIDTH'(COL_STROBE_CYCLES - 1));
    wire logic phase_end_rsu = (phase_q == PHASE_COUNT_WIDTH'(REFRESH_SETUP_CYCLES - 1));
    wire logic phase_end_rfs = (phase_q == PHASE_COUNT_WIDTH'(REFRESH_STROBE_CYCLES - 1));
    wire logic phase_end_pre = (phase_q == PHASE_COUNT_WIDTH'(PRECHARGE_CYCLES - 1));
    // only a held host access waits here; refresh and test cycles leave on their own
    wire logic pre_exit = phase_end_pre && (!acc_q || test_q || !(rd_act || wr_act));
    // a refresh stays pending past the interval only if the host holds an access in PRECHARGE
    wire logic mux_sel_col = (state_q == ACCESS_COL);
    wire logic mux_sel_ref = (state_q == REFRESH_SETUP) || (state_q == REFRESH_STROBE);
    wire logic [1:0] mux_sel = mux_sel_ref ? MUX_REFRESH : (mux_sel_col ? MUX_COL : MUX_ROW);
    wire logic [ADDR_WIDTH-1:0] mux_out;

    addr_select u_addr_select (
        .sel(mux_sel),
        .row_addr(row_addr),
        .col_addr(col_addr),
        .refresh_addr(refresh_row_q),
        .addr_out(mux_out)
    );

    // interval timer: one refresh per 15.6 us keeps 256 rows inside 4 ms
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            interval_q <= '0;
            refresh_due_q <= 1'b0;
        end else begin
            interval_q <= interval_done ? '0 : interval_q + 9'h001;
            // a new tick wins over the take of the previous one
            refresh_due_q <= interval_done || (refresh_due_q && !refresh_taken);
        end
    end

    always_comb begin
        state_d = state_q;
        phase_d = phase_inc;
        refresh_row_d = refresh_row_q;
        test_d = test_q;
        write_d = write_q;
        acc_d = acc_q;
        bank_d = bank;
        unique case (state_q)
            IDLE: begin
                phase_d = '0;
                if (refresh_due_q) begin
                    state_d = REFRESH_SETUP;
                end else if (test_req) begin
                    refresh_row_d = ROW_COUNT_RESET;
                    test_d = 1'b1;
                    acc_d = 1'b1;
                    write_d = 1'b1;
                    state_d = ACCESS_ROW;
                end else if (mem_req) begin
                    write_d = wr_act;
                    acc_d = 1'b1;
                    state_d = ACCESS_ROW;
                end
            end
            ACCESS_ROW: if (phase_end_row) begin
                phase_d = '0;
                state_d = ACCESS_COL;
            end
            ACCESS_COL: if (phase_end_col) begin
                phase_d = '0;
                state_d = PRECHARGE;
            end
            REFRESH_SETUP: if (phase_end_rsu) begin
                phase_d = '0;
                state_d = REFRESH_STROBE;
            end
            REFRESH_STROBE: if (phase_end_rfs) begin
                phase_d = '0;
                refresh_row_d = refresh_row_q + 8'h01;
                state_d = PRECHARGE;
            end
            PRECHARGE: if (pre_exit) begin
                phase_d = '0;
                test_d = 1'b0;
                acc_d = 1'b0;
                state_d = IDLE;
            end else if (phase_end_pre) begin
                phase_d = phase_q;
            end
        endcase
    end

    wire logic in_access = (state_q == ACCESS_ROW) || (state_q == ACCESS_COL);
    wire logic ras_hold = in_access || (state_q == REFRESH_STROBE);
    wire logic [3:0] ras_d;
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_ras
            assign ras_d[b] = !(ras_hold && (mux_sel_ref || bank_q == 2'(b)));
        end
    endgenerate
    wire logic col_active_next = (state_d == ACCESS_COL);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= IDLE;
            phase_q <= '0;
            refresh_row_q <= ROW_COUNT_RESET;
            test_q <= 1'b0;
            write_q <= 1'b0;
            acc_q <= 1'b0;
            bank_q <= 2'h0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            refresh_row_q <= refresh_row_d;
            test_q <= test_d;
            write_q <= write_d;
            acc_q <= acc_d;
            bank_q <= (state_q == IDLE) ? bank_d : bank_q;
        end
    end

    // registered outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ram_addr_out <= 7'h00;
            ram_addr_out_bit7 <= 1'b0;
            row_strobe_n <= 4'hF;
            col_strobe_n <= 1'b1;
            ram_write_n <= 1'b1;
            cycle_ack <= 1'b0;
        end else begin
            ram_addr_out <= mux_out[6:0];
            ram_addr_out_bit7 <= large_mode ? mux_out[7] : 1'b0;
            row_strobe_n <= ras_d;
            col_strobe_n <= !(col_active_next && phase_d >= PHASE_COUNT_WIDTH'(ROW_HOLD_CYCLES));
            ram_write_n <= !(in_access && write_q);
            cycle_ack <= (state_q == PRECHARGE) && acc_q && !test_q && (state_d == PRECHARGE);
        end
    end
endmodule

// ===== verilog/dram_ctrl_pkg.sv
// shared constants for the dynamic ram controller core
package dram_ctrl_pkg;
    localparam int CLOCK_HZ = 25000000;
    localparam int CLOCK_PERIOD_NS = 40;
    // refresh interval, as a longest time, in nanoseconds
    localparam int REFRESH_INTERVAL_NS = 15600;
    localparam int REFRESH_INTERVAL_CYCLES = REFRESH_INTERVAL_NS / CLOCK_PERIOD_NS;
    localparam int ADDR_WIDTH = 8;
    localparam int ROW_COUNT_WIDTH = 8;
    localparam logic [7:0] ROW_COUNT_RESET = 8'h00;
    // strobe phases in whole clock periods
    localparam int ROW_HOLD_CYCLES = 1;
    localparam int ROW_TO_COL_CYCLES = 2;
    localparam int COL_STROBE_CYCLES = 5;
    localparam int PRECHARGE_CYCLES = 4;
    localparam int REFRESH_SETUP_CYCLES = 1;
    localparam int REFRESH_STROBE_CYCLES = 6;
    localparam int PHASE_COUNT_WIDTH = 4;
    localparam int REFRESH_COUNT_WIDTH = 9;
    localparam logic [1:0] MUX_ROW = 2'h0;
    localparam logic [1:0] MUX_COL = 2'h1;
    localparam logic [1:0] MUX_REFRESH = 2'h2;
endpackage

// ===== verilog/addr_select.sv
// three-input address selector for the ram address outputs
`timescale 1ns/1ps
module addr_select
    import dram_ctrl_pkg::*;
(
    input wire logic [1:0] sel,
    input wire logic [ADDR_WIDTH-1:0] row_addr,
    input wire logic [ADDR_WIDTH-1:0] col_addr,
    input wire logic [ADDR_WIDTH-1:0] refresh_addr,
    output logic [ADDR_WIDTH-1:0] addr_out
);
    wire logic pick_col = (sel == MUX_COL);
    wire logic pick_refresh = (sel == MUX_REFRESH);
    assign addr_out = pick_refresh ? refresh_addr : (pick_col ? col_addr : row_addr);
endmodule

// ===== tb/dram_ctrl_checker.sv
// port assertions for the controller core
`timescale 1ns/1ps
module dram_ctrl_checker
    import dram_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [6:0] ram_addr_out,
    input wire logic [3:0] row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic cycle_ack
);
    // slack over 390 covers an access already under way when refresh falls due
    localparam int RF_MAX = 410;
    logic [9:0] gap_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) gap_q <= 10'h000;
        else if (row_strobe_n == 4'h0) gap_q <= 10'h000;
        else gap_q <= gap_q + 10'h001;
    end
    sequence s_rf_start;
        row_strobe_n == 4'h0 && $past(row_strobe_n) == 4'hF;
    endsequence
    sequence s_rf_body;
        (row_strobe_n == 4'h0 && $stable(ram_addr_out))[*6] ##1 row_strobe_n == 4'hF;
    endsequence
    property p_rf_hold;
        s_rf_start |-> s_rf_body;
    endproperty
    property p_gap;
        gap_q <= RF_MAX;
    endproperty
    property p_col_in_row;
        !col_strobe_n |-> row_strobe_n != 4'hF;
    endproperty
    property p_rcd;
        $fell(col_strobe_n) |-> $past(row_strobe_n, 2) != 4'hF;
    endproperty
    property p_col_width;
        $fell(col_strobe_n) |-> (!col_strobe_n)[*4];
    endproperty
    property p_one_bank;
        !col_strobe_n |-> $onehot(~row_strobe_n);
    endproperty
    property p_ack;
        cycle_ack |-> col_strobe_n && row_strobe_n == 4'hF;
    endproperty
    property p_reset;
        $rose(resetn) |-> row_strobe_n == 4'hF && col_strobe_n && !cycle_ack;
    endproperty
    a_rf_hold: assert property (p_rf_hold) else $error("refresh strobe bad");
    a_gap: assert property (p_gap) else $error("refresh too late");
    a_col_in_row: assert property (p_col_in_row) else $error("col without row");
    a_rcd: assert property (p_rcd) else $error("row to col too short");
    a_col_width: assert property (p_col_width) else $error("col too short");
    a_one_bank: assert property (p_one_bank) else $error("bank decode bad");
    a_ack: assert property (p_ack) else $error("ack with strobe");
    a_reset: assert property (p_reset) else $error("reset outputs bad");
endmodule
bind dram_refresh_test_addr_mux dram_ctrl_checker chk_i (.clock, .resetn, .ram_addr_out,
    .row_strobe_n, .col_strobe_n, .cycle_ack);

// ===== tb/dram_bank_model.sv
// ram banks: record what each strobe edge latches
`timescale 1ns/1ps
module dram_bank_model (
    input wire logic clock,
    input wire logic [7:0] addr,
    input wire logic [3:0] row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic ram_write_n,
    output logic [7:0] row_q,
    output logic [7:0] col_q,
    output logic [7:0] rf_q,
    output logic [3:0] bank_q,
    output logic wr_q,
    output logic [15:0] rf_n
);
    logic [3:0] rs_q = 4'hF;
    logic cs_q = 1'b1;
    initial rf_n = 16'h0000;
    always @(posedge clock) begin
        rs_q <= row_strobe_n;
        cs_q <= col_strobe_n;
        if (row_strobe_n == 4'h0 && rs_q == 4'hF) begin
            rf_q <= addr;
            rf_n <= rf_n + 16'h0001;
        end else if (row_strobe_n != 4'hF && rs_q == 4'hF) begin
            row_q <= addr;
            bank_q <= ~row_strobe_n;
        end
        if (!col_strobe_n && cs_q) begin
            col_q <= addr;
            wr_q <= !ram_write_n;
        end
    end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the controller core
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic read_req_n = 1'b1, write_req_n = 1'b1, port_chip_select_n = 1'b1;
    logic [6:0] low_half_addr_in = 7'h00, high_half_addr_in = 7'h00;
    logic low_half_addr_bit7_in = 1'b0, high_half_addr_bit7_in = 1'b0;
    logic [1:0] bank_select_in = 2'h0;
    logic bank_select_bit0 = 1'b0, ram_density_select = 1'b1;
    logic [6:0] ram_addr_out;
    logic ram_addr_out_bit7, col_strobe_n, ram_write_n, cycle_ack, s_wr;
    logic [3:0] row_strobe_n, s_bank;
    logic [7:0] s_row, s_col, s_rf;
    logic [15:0] rf_n;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    dram_refresh_test_addr_mux uut (.clock, .resetn, .read_req_n, .write_req_n,
        .port_chip_select_n, .low_half_addr_in, .high_half_addr_in, .low_half_addr_bit7_in,
        .high_half_addr_bit7_in, .bank_select_in, .bank_select_bit0, .ram_density_select,
        .ram_addr_out, .ram_addr_out_bit7, .row_strobe_n, .col_strobe_n, .ram_write_n,
        .cycle_ack);
    dram_bank_model bank_i (.clock, .addr({ram_addr_out_bit7, ram_addr_out}), .row_strobe_n,
        .col_strobe_n, .ram_write_n, .row_q(s_row), .col_q(s_col), .rf_q(s_rf),
        .bank_q(s_bank), .wr_q(s_wr), .rf_n);
    initial forever #20 clock = ~clock;
    task automatic print_verdict();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic rd, input logic [1:0] bk, input logic [7:0] row, col);
        int n;
        {low_half_addr_bit7_in, low_half_addr_in} = row;
        {high_half_addr_bit7_in, high_half_addr_in} = col;
        // in large-ram mode the unused bank_select_in disagrees so a wrong decode picks another bank
        bank_select_in = ram_density_select ? bk : ~bk;
        bank_select_bit0 = bk[0];
        {read_req_n, write_req_n, port_chip_select_n} = {!rd, rd, 1'b0};
        for (n = 0; n < 60 && cycle_ack !== 1'b1; n++) @(negedge clock);
        chk({7'h00, cycle_ack}, 8'h01);
        {read_req_n, write_req_n, port_chip_select_n} = 3'h7;
        repeat (3) @(negedge clock);
        chk({7'h00, cycle_ack}, 8'h00);
    endtask
    task automatic wait_rf();
        int n;
        logic [15:0] c;
        c = rf_n;
        for (n = 0; n < 500 && rf_n === c; n++) @(negedge clock);
        chk({7'h00, rf_n !== c}, 8'h01);
    endtask
    task automatic t_idle();
        {low_half_addr_bit7_in, low_half_addr_in} = 8'hA5;
        repeat (4) @(negedge clock);
        chk({ram_addr_out_bit7, ram_addr_out}, 8'h25);
        ram_density_select = 1'b0;
        repeat (4) @(negedge clock);
        chk({ram_addr_out_bit7, ram_addr_out}, 8'hA5);
        ram_density_select = 1'b1;
        repeat (4) @(negedge clock);
    endtask
    task automatic t_access();
        for (int b = 0; b < 4; b++) begin
            acc(b[0], b[1:0], 8'h10 + b[7:0], 8'h6A - b[7:0]);
            chk({4'h0, s_bank}, 8'h01 << b);
            chk(s_row, 8'h10 + b[7:0]);
            chk(s_col, 8'h6A - b[7:0]);
            chk({7'h00, s_wr}, {7'h00, !b[0]});
        end
    endtask
    task automatic t_large();
        ram_density_select = 1'b0;
        repeat (3) @(negedge clock);
        acc(1'b1, 2'h1, 8'h9C, 8'hE1);
        chk({4'h0, s_bank}, 8'h02);
        chk(s_row, 8'h9C);
        chk(s_col, 8'hE1);
        ram_density_select = 1'b1;
    endtask
    task automatic t_refresh();
        logic [7:0] first;
        wait_rf();
        first = s_rf;
        wait_rf();
        chk(s_rf, first + 8'h01);
    endtask
    task automatic t_test();
        int n;
        {read_req_n, write_req_n, port_chip_select_n} = 3'h0;
        for (n = 0; n < 60 && col_strobe_n !== 1'b0; n++) @(negedge clock);
        {read_req_n, write_req_n, port_chip_select_n} = 3'h7;
        repeat (2) @(negedge clock);
        chk({7'h00, s_wr}, 8'h01);
        wait_rf();
        chk(s_rf, 8'h00);
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        t_idle();
        t_access();
        t_large();
        t_refresh();
        t_test();
        print_verdict();
    end
endmodule
